// *** cfd_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the cable diagnostic
`ifndef CFD_REGS_SVH
`define CFD_REGS_SVH
`define CFD_P1_DIAG 8'h1a
`define CFD_P1_DIST 8'h1b
`define CFD_P1_CTRL12 8'h1c
`define CFD_P1_CTRL13 8'h1d
`define CFD_PORT_SPAN 8'h50
`define CFD_ADJ_A 8'h27
`define CFD_ADJ_SEL 8'h37
`define CFD_ADJ_MASK 8'h47
`define CFD_DIAG_START_BIT 4
`define CFD_DIAG_RES_LSB 5
`define CFD_DIAG_DMSB_BIT 0
`define CFD_C12_AN_OFF_BIT 7
`define CFD_C12_F100_BIT 6
`define CFD_C12_FFD_BIT 5
`define CFD_C13_MDIX_OFF_BIT 2
`define CFD_C12_RST 8'h0f
`define CFD_C13_RST 8'h00
`define CFD_ADJ_RST 8'h00
`define CFD_DIST_MAX 9'h1f4
`define CFD_CLK_MHZ 10
`define CFD_QUIET_WAIT_US 50
`define CFD_ECHO_WAIT_US 20
`define CFD_QUIET_CYC (`CFD_QUIET_WAIT_US * `CFD_CLK_MHZ)
`define CFD_ECHO_CYC (`CFD_ECHO_WAIT_US * `CFD_CLK_MHZ)
`endif

// *** cfd_pkg.sv ***
// Types shared by the cable diagnostic files
package cfd_pkg;
	typedef enum logic [4:0] {
		CFD_IDLE = 5'h01,
		CFD_QUIET = 5'h02,
		CFD_PULSE = 5'h04,
		CFD_ECHO = 5'h08,
		CFD_DONE = 5'h10
	} cfd_state_t;
	typedef enum logic [1:0] {
		CFD_RES_NORMAL = 2'h0,
		CFD_RES_OPEN = 2'h1,
		CFD_RES_SHORT = 2'h2,
		CFD_RES_INVALID = 2'h3
	} cfd_result_t;
	typedef enum logic [1:0] {
		CFD_M10HD = 2'h0,
		CFD_M10FD = 2'h1,
		CFD_M100HD = 2'h2,
		CFD_M100FD = 2'h3
	} cfd_mode_t;
endpackage

// *** cfd_port_diag.sv ***
// One port's reflectometry test sequencer
`timescale 1ns/1ns
`include "cfd_regs.svh"
module cfd_port_diag (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start_req,
	input wire logic copper,
	input wire logic partner_quiet,
	input wire logic echo_valid,
	input wire logic [1:0] echo_kind,
	input wire logic [8:0] echo_count,
	output logic busy_r,
	output logic [1:0] result_r,
	output logic [8:0] distance_r,
	output logic silence_req_r,
	output logic launch_r
);
	localparam logic [15:0] QUIET_CYC = 16'(`CFD_QUIET_CYC);
	localparam logic [15:0] ECHO_CYC = 16'(`CFD_ECHO_CYC);
	cfd_pkg::cfd_state_t state_r;
	logic [15:0] cnt_r;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_r <= cfd_pkg::CFD_IDLE;
			cnt_r <= 16'h0000;
			result_r <= cfd_pkg::CFD_RES_NORMAL;
			distance_r <= 9'h000;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			case (state_r)
				cfd_pkg::CFD_IDLE: begin
					cnt_r <= 16'h0000;
					if (start_req && !copper) begin
						result_r <= cfd_pkg::CFD_RES_INVALID;
						distance_r <= 9'h000;
						state_r <= cfd_pkg::CFD_DONE;
					end else if (start_req) begin
						state_r <= cfd_pkg::CFD_QUIET;
					end
				end
				cfd_pkg::CFD_QUIET: begin
					if (partner_quiet) begin
						state_r <= cfd_pkg::CFD_PULSE;
					end else if (cnt_r == QUIET_CYC - 16'h0001) begin
						// Partner still talking: no measurement
						result_r <= cfd_pkg::CFD_RES_INVALID;
						distance_r <= 9'h000;
						state_r <= cfd_pkg::CFD_DONE;
					end
				end
				cfd_pkg::CFD_PULSE: begin
					cnt_r <= 16'h0000;
					state_r <= cfd_pkg::CFD_ECHO;
				end
				cfd_pkg::CFD_ECHO: begin
					if (echo_valid) begin
						result_r <= echo_kind;
						// Range ends at 200 m
						distance_r <= (echo_count > `CFD_DIST_MAX) ? `CFD_DIST_MAX : echo_count;
						state_r <= cfd_pkg::CFD_DONE;
					end else if (cnt_r == ECHO_CYC - 16'h0001) begin
						// No reflection inside the window
						result_r <= cfd_pkg::CFD_RES_NORMAL;
						distance_r <= 9'h000;
						state_r <= cfd_pkg::CFD_DONE;
					end
				end
				cfd_pkg::CFD_DONE: begin
					state_r <= cfd_pkg::CFD_IDLE;
				end
				default: begin
					state_r <= cfd_pkg::CFD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			busy_r <= 1'b0;
		end else if (state_r == cfd_pkg::CFD_IDLE && start_req) begin
			busy_r <= 1'b1;
		end else if (state_r == cfd_pkg::CFD_DONE) begin
			busy_r <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			silence_req_r <= 1'b0;
			launch_r <= 1'b0;
		end else begin
			silence_req_r <= (state_r == cfd_pkg::CFD_QUIET) || (state_r == cfd_pkg::CFD_PULSE)
				|| (state_r == cfd_pkg::CFD_ECHO);
			launch_r <= (state_r == cfd_pkg::CFD_QUIET) && partner_quiet;
		end
	end
endmodule

// *** cfd_an_resolve.sv ***
// Speed and duplex resolution for one copper port
`timescale 1ns/1ns
module cfd_an_resolve (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic copper,
	input wire logic an_off,
	input wire logic force_100,
	input wire logic force_fd,
	input wire logic [3:0] local_adv,
	input wire logic partner_adv_valid,
	input wire logic [3:0] partner_adv,
	input wire logic pd_valid,
	input wire logic pd_100,
	output logic link_up_r,
	output logic [1:0] mode_r
);
	logic [3:0] common;

	assign common = local_adv & partner_adv;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			link_up_r <= 1'b0;
			mode_r <= cfd_pkg::CFD_M10HD;
		end else if (!copper) begin
			link_up_r <= 1'b0;
		end else if (an_off) begin
			link_up_r <= pd_valid;
			mode_r <= {force_100, force_fd};
		end else if (partner_adv_valid && common != 4'h0) begin
			link_up_r <= 1'b1;
			if (common[3]) begin
				mode_r <= cfd_pkg::CFD_M100FD;
			end else if (common[2]) begin
				mode_r <= cfd_pkg::CFD_M100HD;
			end else if (common[1]) begin
				mode_r <= cfd_pkg::CFD_M10FD;
			end else begin
				mode_r <= cfd_pkg::CFD_M10HD;
			end
		end else if (!partner_adv_valid && pd_valid) begin
			// Fixed signalling seen: half duplex at that speed
			link_up_r <= 1'b1;
			mode_r <= pd_100 ? cfd_pkg::CFD_M100HD : cfd_pkg::CFD_M10HD;
		end else begin
			link_up_r <= 1'b0;
		end
	end
endmodule

// *** cfd_ctrl.sv ***
// Cable fault diagnostic control for five ports, with its byte register file
`timescale 1ns/1ns
`include "cfd_regs.svh"
module cfd_ctrl (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [4:0] port_copper,
	input wire logic [4:0] refl_partner_quiet,
	input wire logic [4:0] refl_echo_valid,
	input wire logic [9:0] refl_echo_kind,
	input wire logic [44:0] refl_echo_count,
	output logic [4:0] refl_silence_req,
	output logic [4:0] refl_launch,
	output logic [4:0] an_disable,
	output logic [4:0] mdix_manual,
	input wire logic [4:0] partner_adv_valid,
	input wire logic [19:0] partner_adv,
	input wire logic [4:0] pd_valid,
	input wire logic [4:0] pd_100,
	output logic [4:0] link_up,
	output logic [9:0] link_mode,
	output logic [7:0] adj_a,
	output logic [7:0] adj_port_sel,
	output logic [7:0] adj_mask
);
	logic [7:0] ctrl12_r [5];
	logic [7:0] ctrl13_r [5];
	logic [7:0] adj_a_r;
	logic [7:0] adj_sel_r;
	logic [7:0] adj_mask_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;
	logic [4:0] busy;
	logic [4:0] start_req;
	logic [1:0] result [5];
	logic [8:0] distance [5];
	logic wr_hit;
	logic [2:0] wr_port;
	logic [1:0] wr_kind;
	logic rd_hit;
	logic [2:0] rd_port;
	logic [1:0] rd_kind;

	// Per-port window decode: hit, port index, register within the port
	function automatic logic [5:0] port_decode(input logic [7:0] addr);
		logic [7:0] ofs;
		ofs = addr - `CFD_P1_DIAG;
		if (ofs < `CFD_PORT_SPAN && ofs[3:2] == 2'h0) begin
			port_decode = {1'b1, ofs[6:4], ofs[1:0]};
		end else begin
			port_decode = 6'h00;
		end
	endfunction

	assign {wr_hit, wr_port, wr_kind} = port_decode(reg_addr);
	assign {rd_hit, rd_port, rd_kind} = port_decode(reg_addr);

	genvar p;
	generate
		for (p = 0; p < 5; p = p + 1) begin : g_port
			// Start taken only while idle; bit stays set until done
			assign start_req[p] = reg_wr && wr_hit && wr_port == 3'(p) && wr_kind == 2'h0
				&& reg_wdata[`CFD_DIAG_START_BIT] && !busy[p];

			cfd_port_diag u_diag (
				.clock(clock),
				.rst_b(rst_b),
				.start_req(start_req[p]),
				.copper(port_copper[p]),
				.partner_quiet(refl_partner_quiet[p]),
				.echo_valid(refl_echo_valid[p]),
				.echo_kind(refl_echo_kind[2*p+1 -: 2]),
				.echo_count(refl_echo_count[9*p+8 -: 9]),
				.busy_r(busy[p]),
				.result_r(result[p]),
				.distance_r(distance[p]),
				.silence_req_r(refl_silence_req[p]),
				.launch_r(refl_launch[p])
			);

			cfd_an_resolve u_an (
				.clock(clock),
				.rst_b(rst_b),
				.copper(port_copper[p]),
				.an_off(ctrl12_r[p][`CFD_C12_AN_OFF_BIT]),
				.force_100(ctrl12_r[p][`CFD_C12_F100_BIT]),
				.force_fd(ctrl12_r[p][`CFD_C12_FFD_BIT]),
				.local_adv(ctrl12_r[p][3:0]),
				.partner_adv_valid(partner_adv_valid[p]),
				.partner_adv(partner_adv[4*p+3 -: 4]),
				.pd_valid(pd_valid[p]),
				.pd_100(pd_100[p]),
				.link_up_r(link_up[p]),
				.mode_r(link_mode[2*p+1 -: 2])
			);

			assign an_disable[p] = ctrl12_r[p][`CFD_C12_AN_OFF_BIT];
			assign mdix_manual[p] = ctrl13_r[p][`CFD_C13_MDIX_OFF_BIT];
		end
	endgenerate

	// Port control registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int i = 0; i < 5; i++) begin
				ctrl12_r[i] <= `CFD_C12_RST;
				ctrl13_r[i] <= `CFD_C13_RST;
			end
		end else if (reg_wr && wr_hit && wr_port < 3'h5) begin
			if (wr_kind == 2'h2) begin
				ctrl12_r[wr_port] <= reg_wdata;
			end
			if (wr_kind == 2'h3) begin
				ctrl13_r[wr_port] <= reg_wdata;
			end
		end
	end

	// Temporary adjustment registers used during set-up
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			adj_a_r <= `CFD_ADJ_RST;
			adj_sel_r <= `CFD_ADJ_RST;
			adj_mask_r <= `CFD_ADJ_RST;
		end else if (reg_wr) begin
			if (reg_addr == `CFD_ADJ_A) begin
				adj_a_r <= reg_wdata;
			end
			if (reg_addr == `CFD_ADJ_SEL) begin
				adj_sel_r <= reg_wdata;
			end
			if (reg_addr == `CFD_ADJ_MASK) begin
				adj_mask_r <= reg_wdata;
			end
		end
	end

	assign adj_a = adj_a_r;
	assign adj_port_sel = adj_sel_r;
	assign adj_mask = adj_mask_r;

	// Read mux
	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_hit && rd_port < 3'h5) begin
			case (rd_kind)
				2'h0: begin
					rdata_nxt[`CFD_DIAG_RES_LSB +: 2] = result[rd_port];
					rdata_nxt[`CFD_DIAG_START_BIT] = busy[rd_port];
					rdata_nxt[`CFD_DIAG_DMSB_BIT] = distance[rd_port][8];
				end
				2'h1: begin
					rdata_nxt = distance[rd_port][7:0];
				end
				2'h2: begin
					rdata_nxt = ctrl12_r[rd_port];
				end
				2'h3: begin
					rdata_nxt = ctrl13_r[rd_port];
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end else if (reg_addr == `CFD_ADJ_A) begin
			rdata_nxt = adj_a_r;
		end else if (reg_addr == `CFD_ADJ_SEL) begin
			rdata_nxt = adj_sel_r;
		end else if (reg_addr == `CFD_ADJ_MASK) begin
			rdata_nxt = adj_mask_r;
		end
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
endmodule

// *** cfd_ctrl_chk.sv ***
// Port assertions for the cable diagnostic control
`timescale 1ns/1ns
module cfd_ctrl_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [4:0] port_copper,
	input wire logic [4:0] refl_partner_quiet,
	input wire logic [4:0] refl_silence_req,
	input wire logic [4:0] refl_launch,
	input wire logic [4:0] an_disable,
	input wire logic [4:0] mdix_manual,
	input wire logic [7:0] adj_mask
);
	logic [9:0] run_cnt_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Length of one port 1 test
	always_ff @(posedge clock) begin
		if (!rst_b || !refl_silence_req[0])
			run_cnt_r <= 10'h000;
		else
			run_cnt_r <= run_cnt_r + 10'h001;
	end
	property p_rd; reg_rd |=> reg_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read unanswered");
	property p_unmap; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_go;
		reg_wr && reg_addr == 8'h1a && reg_wdata[4] && port_copper[0] && !refl_silence_req[0]
			|-> ##[1:2] refl_silence_req[0];
	endproperty
	a_go: assert property (p_go) else $error("test not started");
	property p_fire; refl_launch[0] |-> $past(refl_partner_quiet[0]) && refl_silence_req[0]; endproperty
	a_fire: assert property (p_fire) else $error("pulse without quiet");
	property p_cu; !port_copper[0] |-> !refl_launch[0]; endproperty
	a_cu: assert property (p_cu) else $error("pulse on non-copper");
	property p_len; run_cnt_r < 10'h2d0; endproperty
	a_len: assert property (p_len) else $error("test too long");
	property p_an; reg_wr && reg_addr == 8'h1c |=> an_disable[0] == $past(reg_wdata[7]); endproperty
	a_an: assert property (p_an) else $error("an_disable wrong");
	property p_mx; reg_wr && reg_addr == 8'h1d |=> mdix_manual[0] == $past(reg_wdata[2]); endproperty
	a_mx: assert property (p_mx) else $error("mdix_manual wrong");
	property p_adj; reg_wr && reg_addr == 8'h47 |=> adj_mask == $past(reg_wdata); endproperty
	a_adj: assert property (p_adj) else $error("adj_mask wrong");
	c_fire: cover property (refl_launch[0]);
	c_long: cover property (run_cnt_r == 10'h1f0);
	c_unmap: cover property (reg_rd && reg_addr == 8'h00);
endmodule
bind cfd_ctrl cfd_ctrl_chk u_chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .port_copper(port_copper), .refl_partner_quiet(refl_partner_quiet),
	.refl_silence_req(refl_silence_req), .refl_launch(refl_launch), .an_disable(an_disable),
	.mdix_manual(mdix_manual), .adj_mask(adj_mask));

// *** cfd_refl_model.sv ***
// Analog front end and far partner of the reflectometry test
`timescale 1ns/1ns
module cfd_refl_model (
	input wire logic clock,
	input wire logic [4:0] silence_req,
	input wire logic [4:0] launch,
	input wire logic [4:0] deaf,
	input wire logic [7:0] echo_dly,
	input wire logic [9:0] kind,
	input wire logic [44:0] count,
	output logic [4:0] quiet_r,
	output logic [4:0] echo_valid_r,
	output logic [9:0] echo_kind,
	output logic [44:0] echo_count
);
	logic [7:0] wait_r [5];
	logic [4:0] armed_r = 5'h00;
	initial quiet_r = 5'h00;
	initial echo_valid_r = 5'h00;
	always @(posedge clock) begin
		quiet_r <= silence_req & ~deaf;
		for (int i = 0; i < 5; i++) begin
			echo_valid_r[i] <= 1'b0;
			if (launch[i]) begin
				armed_r[i] <= 1'b1;
				wait_r[i] <= echo_dly;
			end else if (armed_r[i] && wait_r[i] == 8'h00) begin
				armed_r[i] <= 1'b0;
				echo_valid_r[i] <= 1'b1;
			end else if (armed_r[i]) begin
				wait_r[i] <= wait_r[i] - 8'h01;
			end
		end
	end
	// Outside the echo the lines show inverted values
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			echo_kind[2*i+:2] = echo_valid_r[i] ? kind[2*i+:2] : ~kind[2*i+:2];
			echo_count[9*i+:9] = echo_valid_r[i] ? count[9*i+:9] : ~count[9*i+:9];
		end
	end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the cable diagnostic control
`timescale 1ns/1ns
`include "cfd_regs.svh"
module tb_top;
	logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, adj_a, adj_port_sel, adj_mask;
	logic [7:0] echo_dly = 0;
	logic [4:0] port_copper = 5'h1f, deaf = 0, partner_adv_valid = 0, pd_valid = 0, pd_100 = 0;
	logic [4:0] refl_partner_quiet, refl_echo_valid, refl_silence_req, refl_launch;
	logic [4:0] an_disable, mdix_manual, link_up;
	logic [9:0] kind = 0, refl_echo_kind, link_mode;
	logic [19:0] partner_adv = 0;
	logic [44:0] count = 0, refl_echo_count;
	logic [15:0] saved [5];
	int exp_q [$];
	logic [31:0] rs = 32'hdb3a;
	int error_cnt = 0, tests_run = 0;
	always #50 clock = ~clock;
	cfd_ctrl dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_rvalid, .port_copper, .refl_partner_quiet, .refl_echo_valid, .refl_echo_kind,
		.refl_echo_count, .refl_silence_req, .refl_launch, .an_disable, .mdix_manual,
		.partner_adv_valid, .partner_adv, .pd_valid, .pd_100, .link_up, .link_mode, .adj_a,
		.adj_port_sel, .adj_mask);
	cfd_refl_model u_far (.clock, .silence_req(refl_silence_req), .launch(refl_launch), .deaf,
		.echo_dly, .kind, .count, .quiet_r(refl_partner_quiet), .echo_valid_r(refl_echo_valid),
		.echo_kind(refl_echo_kind), .echo_count(refl_echo_count));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		chk("rvalid", reg_rvalid, 1'b1);
	endtask
	task automatic nap;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic run(input int p, input logic [1:0] k, input logic [8:0] c, input logic ck);
		logic [7:0] b, d, r;
		int n;
		int e;
		b = 8'h1a + 8'(16 * p);
		exp_q.push_back(int'(k) * 512 + int'(c > `CFD_DIST_MAX ? `CFD_DIST_MAX : c));
		wr(b + 8'h02, 8'hff);
		wr(b + 8'h03, 8'h04);
		kind[2*p+:2] <= k;
		count[9*p+:9] <= c;
		echo_dly <= 8'(rs % 16);
		wr(b, 8'h10);
		rd(b, d);
		chk("busy", d[4], port_copper[p]);
		for (n = 0; n < 1000 && d[4]; n++)
			rd(b, d);
		chk("done", d[4], 1'b0);
		e = exp_q.pop_front();
		chk("result", d[6:5], 16'(e / 512));
		rd(b + 8'h01, r);
		if (ck)
			chk("dist", {d[0], r}, 16'(e % 512));
		chk("metres", 16'(({d[0], r} * 2) / 5 <= 200), 16'h0001);
		saved[p] = {d, r};
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#2000000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		logic [7:0] d, r;
		logic [3:0] cm;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		for (int p = 0; p < 5; p++) begin
			rd(8'h1c + 8'(16 * p), d);
			chk("ctrl12", d, 8'h0f);
			rd(8'h1d + 8'(16 * p), d);
			chk("ctrl13", d, 8'h00);
		end
		rd(8'h00, d);
		chk("unmapped", d, 8'h00);
		rs = xs(rs);
		wr(8'h27, rs[7:0]);
		rd(8'h27, d);
		chk("adj a", adj_a, rs[7:0]);
		chk("adj a read", d, rs[7:0]);
		$display("test reset done");
		for (int p = 0; p < 5; p++) begin
			wr(8'h47, 8'hb0);
			wr(8'h27, 8'h00);
			wr(8'h37, 8'h03 + 8'(p));
			wr(8'h47, 8'h80 >> p);
			nap();
			chk("sel", adj_port_sel, 8'h03 + 8'(p));
			chk("mask", adj_mask, 8'h80 >> p);
			wr(8'h27, 8'h00);
			wr(8'h37, 8'h00);
			rs = xs(rs);
			run(p, 2'(p), 9'(rs), 1'b1);
			wr(8'h47, 8'h00);
		end
		nap();
		chk("adj", {adj_port_sel, adj_mask}, 16'h0000);
		chk("adj a zero", adj_a, 8'h00);
		chk("an_off", {an_disable, mdix_manual}, 10'h3ff);
		chk("forced mode", link_mode, 10'h3ff);
		chk("forced link", link_up, 5'h00);
		$display("test cable runs done");
		@(posedge clock);
		deaf <= 5'h01;
		run(0, 2'h3, 9'h000, 1'b0);
		@(posedge clock);
		deaf <= 5'h00;
		port_copper <= 5'h1e;
		run(0, 2'h3, 9'h000, 1'b0);
		@(posedge clock);
		port_copper <= 5'h1f;
		for (int p = 0; p < 5; p++) begin
			rd(8'h1a + 8'(16 * p), d);
			rd(8'h1b + 8'(16 * p), r);
			chk("held", {d, r}, saved[p]);
		end
		$display("test faults done");
		for (int i = 0; i < 8; i++) begin
			rs = xs(rs);
			cm = rs[3:0] & rs[7:4];
			wr(8'h4c, {4'h0, rs[3:0]});
			partner_adv[15:12] <= rs[7:4];
			partner_adv_valid <= 5'h08;
			nap();
			if (cm != 4'h0) begin
				chk("mode", link_mode[7:6], cm[3] ? 2'h3 : cm[2] ? 2'h2 : {1'b0, cm[1]});
				chk("link", link_up[3], 1'b1);
			end
		end
		@(posedge clock);
		partner_adv_valid <= 5'h00;
		pd_valid <= 5'h08;
		pd_100 <= rs[12:8];
		nap();
		chk("pd mode", link_mode[7:6], {pd_100[3], 1'b0});
		chk("pd link", link_up[3], 1'b1);
		$display("test negotiation done");
		give_verdict();
	end
endmodule
